// file: hdl/gpio_edge_det.sv
`timescale 1ns/100ps
`default_nettype none
// synchronises pin levels and reports single-cycle rise and fall pulses
module gpio_edge_det #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             reset_n_in,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  // synchronised level and edges
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // first stage feeds only the second stage
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
  assign fall_out  = ~sync_q & prev_q;
endmodule // gpio_edge_det
`default_nettype wire

// file: hdl/gpio_map.svh
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

// register byte addresses on the configuration bus
`define GPIO_ADDR_ENABLE    32'h01b0_0000
`define GPIO_ADDR_DIRECTION 32'h01b0_0004
`define GPIO_ADDR_VALUE     32'h01b0_0008
`define GPIO_ADDR_RISE_DET  32'h01b0_0010
`define GPIO_ADDR_RISE_MASK 32'h01b0_0014
`define GPIO_ADDR_FALL_DET  32'h01b0_0018
`define GPIO_ADDR_FALL_MASK 32'h01b0_001c
`define GPIO_ADDR_GLOBAL    32'h01b0_0020
`define GPIO_ADDR_POLARITY  32'h01b0_0024
`define GPIO_ADDR_HOLE      32'h01b0_000c

// reset values
`define GPIO_RST_ENABLE     16'h0000
`define GPIO_RST_DIRECTION  16'h0000
`define GPIO_RST_WORD       16'h0000
`define GPIO_RST_GLOBAL     8'h00

// global control fields
`define GPIO_GC_MODE_LSB    0
`define GPIO_GC_MODE_W      2
`define GPIO_GC_LOGIC_BIT   4

// input hold figures in cpu clock periods
`define GPIO_EVENT_HOLD_P   8
`define GPIO_POLL_HOLD_P    12

`endif

// file: hdl/gpio_pkg.sv
package gpio_pkg;
  typedef enum logic [1:0] {
    GPIO_MODE_PASS  = 2'h0,
    GPIO_MODE_DELTA = 2'h1,
    GPIO_MODE_LOGIC = 2'h2,
    GPIO_MODE_RSVD  = 2'h3
  } gpio_mode_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } gpio_bus_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } gpio_bus_rsp_t;
endpackage

// file: hdl/gpio_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpio_map.svh"

// Function
// - sixteen pins 0..15 each have an enable bit and a direction bit at their own index.
// - a pin is under port control only while its enable bit is one.
// - for an enabled pin direction zero means input and direction one means output.
// - direction bits of disabled pins have no effect on the pin.
// - an output pin drives the level software wrote into its value bit.
// - reading the value bit of an input pin returns the sampled pin state.
// - after reset all direction bits are zero and reserved upper bits read zero.
// - pin activity raises cpu interrupt and dma sync events under selectable modes.
// - rise detect, rise mask, fall detect, fall mask, global control and polarity exist.
module gpio_port
  import gpio_pkg::*;
#(
  parameter int PINS = 16
) (
  // clock and reset
  input  wire logic            mclk_in,
  input  wire logic            reset_n_in,
  // configuration bus
  input  wire gpio_bus_req_t   cfg_req_in,
  output gpio_bus_rsp_t        cfg_rsp_out,
  // general pins, enable low while driving
  input  wire logic [PINS-1:0] general_pin_in,
  output logic      [PINS-1:0] general_pin_out,
  output logic      [PINS-1:0] general_pin_oe_n_out,
  // events
  output logic      [PINS-1:0] pin_irq_out,
  output logic      [PINS-1:0] dma_sync_event_out,
  output logic                 logic_irq_out,
  output logic                 logic_dma_sync_event_out
);
  logic [PINS-1:0] enable_q, enable_d;
  logic [PINS-1:0] dir_q, dir_d;
  logic [PINS-1:0] value_q, value_d;
  logic [PINS-1:0] rdet_q, rdet_d;
  logic [PINS-1:0] rmask_q, rmask_d;
  logic [PINS-1:0] fdet_q, fdet_d;
  logic [PINS-1:0] fmask_q, fmask_d;
  logic [PINS-1:0] pol_q, pol_d;
  logic [7:0]      gctl_q, gctl_d;
  logic [31:0]     rdata_q, rdata_d;
  logic            ack_q, ack_d;
  logic [PINS-1:0] pin_irq_q, pin_irq_d;
  logic            logic_q, logic_d;

  logic [PINS-1:0] level;
  logic [PINS-1:0] rise;
  logic [PINS-1:0] fall;
  logic [PINS-1:0] is_in;
  logic [PINS-1:0] is_out;
  logic [PINS-1:0] act;
  logic [PINS-1:0] rise_ev;
  logic [PINS-1:0] fall_ev;
  gpio_mode_t      mode;

  function automatic logic [PINS-1:0] lo(input logic [31:0] w);
    lo = w[PINS-1:0];
  endfunction

  function automatic logic [31:0] zx(input logic [PINS-1:0] v);
    zx = {{(32-PINS){1'b0}}, v};
  endfunction

  function automatic logic hit(input gpio_bus_req_t r, input logic [31:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  gpio_edge_det #(
    .WIDTH(PINS)
  ) u_edge (
    .mclk_in   (mclk_in),
    .reset_n_in(reset_n_in),
    .pin_in    (general_pin_in),
    .level_out (level),
    .rise_out  (rise),
    .fall_out  (fall)
  );

  assign is_out = enable_q & dir_q;
  assign is_in  = enable_q & ~dir_q;
  assign mode   = gpio_mode_t'(gctl_q[`GPIO_GC_MODE_LSB +: `GPIO_GC_MODE_W]);

  // polarity swaps which edge counts as active for event generation
  assign rise_ev = is_in & ((rise & ~pol_q) | (fall & pol_q));
  assign fall_ev = is_in & ((fall & ~pol_q) | (rise & pol_q));

  always_comb begin
    enable_d = enable_q;
    dir_d    = dir_q;
    rmask_d  = rmask_q;
    fmask_d  = fmask_q;
    pol_d    = pol_q;
    gctl_d   = gctl_q;
    // input pins track the pin, outputs keep what software wrote
    value_d  = (value_q & ~is_in) | (level & is_in);
    if (hit(cfg_req_in, `GPIO_ADDR_ENABLE)) begin
      enable_d = lo(cfg_req_in.wdata);
    end
    if (hit(cfg_req_in, `GPIO_ADDR_DIRECTION)) begin
      dir_d = lo(cfg_req_in.wdata);
    end
    if (hit(cfg_req_in, `GPIO_ADDR_VALUE)) begin
      value_d = (lo(cfg_req_in.wdata) & ~is_in) | (level & is_in);
    end
    if (hit(cfg_req_in, `GPIO_ADDR_RISE_MASK)) begin
      rmask_d = lo(cfg_req_in.wdata);
    end
    if (hit(cfg_req_in, `GPIO_ADDR_FALL_MASK)) begin
      fmask_d = lo(cfg_req_in.wdata);
    end
    if (hit(cfg_req_in, `GPIO_ADDR_POLARITY)) begin
      pol_d = lo(cfg_req_in.wdata);
    end
    if (hit(cfg_req_in, `GPIO_ADDR_GLOBAL)) begin
      gctl_d = cfg_req_in.wdata[7:0];
    end
  end

  // detect bits: write one clears, a new edge in the same cycle wins
  always_comb begin
    rdet_d = rdet_q;
    fdet_d = fdet_q;
    if (hit(cfg_req_in, `GPIO_ADDR_RISE_DET)) begin
      rdet_d = rdet_q & ~lo(cfg_req_in.wdata);
    end
    if (hit(cfg_req_in, `GPIO_ADDR_FALL_DET)) begin
      fdet_d = fdet_q & ~lo(cfg_req_in.wdata);
    end
    rdet_d = rdet_d | rise_ev;
    fdet_d = fdet_d | fall_ev;
  end

  // event generation per mode
  always_comb begin
    act       = (rise_ev & rmask_q) | (fall_ev & fmask_q);
    pin_irq_d = '0;
    logic_d   = 1'b0;
    case (mode)
      GPIO_MODE_PASS: begin
        // raw pass-through of the active level of each input pin
        pin_irq_d = is_in & (level ^ pol_q);
      end
      GPIO_MODE_DELTA: begin
        pin_irq_d = act;
      end
      GPIO_MODE_LOGIC: begin
        // and-mode needs all masked pins set, or-mode any one
        if (gctl_q[`GPIO_GC_LOGIC_BIT]) begin
          logic_d = ((rmask_q | fmask_q) != '0) &&
                    (((rdet_d & rmask_q) | (fdet_d & fmask_q)) == (rmask_q | fmask_q));
        end else begin
          logic_d = act != '0;
        end
      end
      default: begin
        pin_irq_d = '0;
      end
    endcase
  end

  // read path, one cycle latency, unmapped reads return zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    ack_d   = cfg_req_in.rd | cfg_req_in.wr;
    if (cfg_req_in.rd) begin
      case (cfg_req_in.addr)
        `GPIO_ADDR_ENABLE:    rdata_d = zx(enable_q);
        `GPIO_ADDR_DIRECTION: rdata_d = zx(dir_q);
        `GPIO_ADDR_VALUE:     rdata_d = zx(value_q);
        `GPIO_ADDR_RISE_DET:  rdata_d = zx(rdet_q);
        `GPIO_ADDR_RISE_MASK: rdata_d = zx(rmask_q);
        `GPIO_ADDR_FALL_DET:  rdata_d = zx(fdet_q);
        `GPIO_ADDR_FALL_MASK: rdata_d = zx(fmask_q);
        `GPIO_ADDR_GLOBAL:    rdata_d = {24'h00_0000, gctl_q};
        `GPIO_ADDR_POLARITY:  rdata_d = zx(pol_q);
        default:              rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      enable_q  <= `GPIO_RST_ENABLE;
      dir_q     <= `GPIO_RST_DIRECTION;
      value_q   <= `GPIO_RST_WORD;
      rdet_q    <= `GPIO_RST_WORD;
      rmask_q   <= `GPIO_RST_WORD;
      fdet_q    <= `GPIO_RST_WORD;
      fmask_q   <= `GPIO_RST_WORD;
      pol_q     <= `GPIO_RST_WORD;
      gctl_q    <= `GPIO_RST_GLOBAL;
      rdata_q   <= 32'h0000_0000;
      ack_q     <= 1'b0;
      pin_irq_q <= '0;
      logic_q   <= 1'b0;
    end else begin
      enable_q  <= enable_d;
      dir_q     <= dir_d;
      value_q   <= value_d;
      rdet_q    <= rdet_d;
      rmask_q   <= rmask_d;
      fdet_q    <= fdet_d;
      fmask_q   <= fmask_d;
      pol_q     <= pol_d;
      gctl_q    <= gctl_d;
      rdata_q   <= rdata_d;
      ack_q     <= ack_d;
      pin_irq_q <= pin_irq_d;
      logic_q   <= logic_d;
    end
  end

  // the two-flop synchroniser plus edge register needs pulses of three
  // clocks; the held-level figures below leave margin over that
  assign general_pin_out          = value_q;
  assign general_pin_oe_n_out     = ~is_out;
  assign pin_irq_out              = pin_irq_q;
  assign dma_sync_event_out       = pin_irq_q;
  assign logic_irq_out            = logic_q;
  assign logic_dma_sync_event_out = logic_q;
  assign cfg_rsp_out.ack          = ack_q;
  assign cfg_rsp_out.rdata        = rdata_q;
endmodule // gpio_port
`default_nettype wire

// file: test/gpio_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// board side of the pins: the port wins wherever it drives, else the board level shows
module gpio_pin_model (
  // port side
  input  wire logic [15:0] drive_in,
  input  wire logic [15:0] oe_n_in,
  // board side
  input  wire logic [15:0] ext_in,
  output logic      [15:0] pin_out
);
  // ext_in is only changed with at least twelve clocks before a poll
  assign pin_out = (~oe_n_in & drive_in) | (oe_n_in & ext_in);
endmodule // gpio_pin_model
`default_nettype wire

// file: test/gpio_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpio_map.svh"
module gpio_port_bench;
  import gpio_pkg::*;
  logic          mclk_in = 1'b0;
  logic          reset_n_in = 1'b0;
  gpio_bus_req_t req = '0;
  gpio_bus_rsp_t rsp;
  logic [15:0]   pin_lvl, pin_o, oe_n;
  logic [15:0]   irq, dma;
  logic          lirq, ldma;
  logic [15:0]   ext_q = 16'h0;
  logic [63:0]   expq[$];
  logic [63:0]   q;
  logic [31:0]   e, r, v, x;
  int            err_total = 0;
  int            num_checks = 0;
  always #2 mclk_in = ~mclk_in;
  gpio_port u_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .cfg_req_in(req),
    .cfg_rsp_out(rsp), .general_pin_in(pin_lvl), .general_pin_out(pin_o),
    .general_pin_oe_n_out(oe_n), .pin_irq_out(irq), .dma_sync_event_out(dma),
    .logic_irq_out(lirq), .logic_dma_sync_event_out(ldma));
  gpio_pin_model u_pins (.drive_in(pin_o), .oe_n_in(oe_n), .ext_in(ext_q), .pin_out(pin_lvl));
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    num_checks++;
    if ((got & m) !== (exp & m)) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got & m, exp & m);
    end
  endtask
  // a read notes data and mask; a write notes an empty mask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    @(posedge mclk_in);
    req <= '{rd: !w, wr: w, addr: a, wdata: d};
    expq.push_back(w ? 64'h0 : {d, m});
    @(posedge mclk_in);
    req <= '0;
  endtask
  task automatic hold_pins(input logic [15:0] lvl);
    @(posedge mclk_in);
    ext_q <= lvl;
    repeat (12) @(posedge mclk_in);
  endtask
  always @(posedge mclk_in) begin
    if (rsp.ack === 1'b1) begin
      if (expq.size() == 0) chk(32'h1, 32'h0, 32'h1);
      else begin
        q = expq.pop_front();
        chk(rsp.rdata, q[63:32], q[31:0]);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    end_of_test();
  end
  initial begin
    r = $urandom(32'h12f0);
    repeat (6) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    bus(0, `GPIO_ADDR_DIRECTION, 32'h0, '1);
    bus(0, `GPIO_ADDR_HOLE, 32'h0, '1);
    bus(1, `GPIO_ADDR_ENABLE, 32'hffff, 0);
    bus(1, `GPIO_ADDR_DIRECTION, r | 32'hffff_0000, 0);
    bus(0, `GPIO_ADDR_DIRECTION, r & 32'hffff, '1);
    @(negedge mclk_in);
    chk(oe_n, ~r[15:0], 32'hffff);
    for (int i = 0; i < 6; i++) begin
      e = $urandom & 32'hffff;
      r = $urandom & 32'hffff;
      v = $urandom & 32'hffff;
      x = $urandom & 32'hffff;
      bus(1, `GPIO_ADDR_ENABLE, e, 0);
      bus(1, `GPIO_ADDR_DIRECTION, r, 0);
      bus(1, `GPIO_ADDR_VALUE, v, 0);
      hold_pins(x[15:0]);
      bus(0, `GPIO_ADDR_VALUE, (e & r & v) | (e & ~r & x), e);
      @(negedge mclk_in);
      chk(oe_n, ~(e[15:0] & r[15:0]), 32'hffff);
      chk(pin_o, v, e & r);
    end
    bus(1, `GPIO_ADDR_ENABLE, 32'hffff, 0);
    bus(1, `GPIO_ADDR_DIRECTION, 32'h0, 0);
    hold_pins(16'h0);
    bus(1, `GPIO_ADDR_RISE_DET, 32'hffff, 0);
    bus(0, `GPIO_ADDR_RISE_DET, 32'h0, '1);
    hold_pins(16'hffff);
    bus(0, `GPIO_ADDR_RISE_DET, 32'hffff, '1);
    // reset mode passes the level of every enabled input pin
    @(negedge mclk_in);
    chk(irq, 32'hffff, 32'hffff);
    chk(dma, 32'hffff, 32'hffff);
    chk({lirq, ldma}, 32'h0, 32'h3);
    bus(1, `GPIO_ADDR_RISE_DET, 32'h0001, 0);
    bus(0, `GPIO_ADDR_RISE_DET, 32'hfffe, '1);
    repeat (4) @(posedge mclk_in);
    end_of_test();
  end
endmodule // gpio_port_bench
bind gpio_port gpio_port_chk #(.PINS(PINS)) u_chk (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
  .cfg_req_in(cfg_req_in), .cfg_rsp_out(cfg_rsp_out), .general_pin_out(general_pin_out),
  .general_pin_oe_n_out(general_pin_oe_n_out));
`default_nettype wire

// file: test/gpio_port_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpio_map.svh"
module gpio_port_chk
  import gpio_pkg::*;
#(
  parameter int PINS = 16
) (
  input wire logic            mclk_in,
  input wire logic            reset_n_in,
  input wire gpio_bus_req_t   cfg_req_in,
  input wire gpio_bus_rsp_t   cfg_rsp_out,
  input wire logic [PINS-1:0] general_pin_out,
  input wire logic [PINS-1:0] general_pin_oe_n_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_req; cfg_req_in.rd || cfg_req_in.wr; endsequence
  sequence s_val_wr; cfg_req_in.wr && cfg_req_in.addr == `GPIO_ADDR_VALUE; endsequence
  property p_ack; s_req |=> cfg_rsp_out.ack; endproperty
  property p_ack_src; cfg_rsp_out.ack |-> $past(cfg_req_in.rd || cfg_req_in.wr); endproperty
  property p_idle; !cfg_rsp_out.ack |-> cfg_rsp_out.rdata == 32'h0; endproperty
  property p_upper; cfg_rsp_out.ack |-> cfg_rsp_out.rdata[31:16] == 16'h0; endproperty
  property p_hole; cfg_req_in.rd && cfg_req_in.addr == `GPIO_ADDR_HOLE |=> cfg_rsp_out.rdata == 32'h0;
  endproperty
  property p_out;
    s_val_wr |=> ((general_pin_out ^ $past(cfg_req_in.wdata[PINS-1:0])) & ~general_pin_oe_n_out) == '0;
  endproperty
  property p_oe; $changed(general_pin_oe_n_out) |-> $past(cfg_req_in.wr); endproperty
  property p_rst; $rose(reset_n_in) |-> general_pin_oe_n_out == '1 && general_pin_out == '0;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  a_ack_src: assert property (p_ack_src) else $error("ack without request");
  a_idle: assert property (p_idle) else $error("read data not zero outside ack");
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  a_out: assert property (p_out) else $error("output pin not at written value");
  a_oe: assert property (p_oe) else $error("driver changed without write");
  a_rst: assert property (p_rst) else $error("pins not inputs after reset");
endmodule // gpio_port_chk
`default_nettype wire
